// ==== common/bafle_pkg.sv ====
// Purpose: Shared constants of the bridge acquisition, FIFO and limit block
// Assumes: 10 MHz aclk, AXI4-Lite register access with 32-bit words
// Notes:   Register offsets are byte addresses
`default_nettype none
package bafle_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_SCNT    = 8'h08;
  localparam logic [7:0] OFS_RDIV    = 8'h0C;
  localparam logic [7:0] OFS_CHEN_LO = 8'h10;
  localparam logic [7:0] OFS_CHEN_HI = 8'h14;
  localparam logic [7:0] OFS_CSRC    = 8'h18;
  localparam logic [7:0] OFS_GAIN    = 8'h1C;
  localparam logic [7:0] OFS_OFFS    = 8'h20;
  localparam logic [7:0] OFS_FTAG    = 8'h24;
  localparam logic [7:0] OFS_FDATA   = 8'h28;
  localparam logic [7:0] OFS_LIM     = 8'h40;
  localparam logic [7:0] OFS_LIM_END = 8'hC0;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_LATCH  = 1;
  localparam int CTRL_SYNC   = 2;
  localparam int ST_OVF      = 8;
  localparam int ST_ACQ      = 9;
  localparam int ST_EMPTY    = 10;
  localparam int LIM_EN_BIT  = 31;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] SCNT_RST = 24'h00_0001;
  localparam logic [23:0] RDIV_RST = 24'h00_2710;
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam logic [3:0]  CSRC_RST = 4'h1;
  // ----------------------------------------------------------------
  // Sizes, codes and timing
  // ----------------------------------------------------------------
  localparam int NCH      = 48;
  localparam int NLINE    = 8;
  localparam int FIFO_AW  = 6;
  localparam int CAL_SH   = 14;
  localparam int IIR_SH   = 12;
  localparam logic signed [7:0] IIR_K = 8'sh29;
  localparam logic [1:0] KIND_MAIN = 2'h0;
  localparam logic [1:0] KIND_CONF = 2'h1;
  localparam logic [1:0] KIND_DIO  = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS        = 100;
  localparam int DIO_PERIOD_NS = 1_000_000;
  localparam int DIO_CYC  = (DIO_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONF_GAP_NS   = 2_000_000;
  localparam int CONF_CYC = (CONF_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage : bafle_pkg
`default_nettype wire

// ==== hw/bafle_limit_line.sv ====
// Purpose: One trigger-bus line driven by min/max limit checks
// Assumes: Samples arrive already filtered and calibrated
// Notes:   Latched or once-per-scan behaviour
`timescale 1ns/1ns
`default_nettype none
module bafle_limit_line (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clr,
  input  wire logic        smp_valid,
  input  wire logic [5:0]  smp_ch,
  input  wire logic [23:0] smp_val,
  input  wire logic        scan_end,
  input  wire logic        latch_en,
  input  wire logic [47:0] mask,
  input  wire logic [24:0] lim_min,
  input  wire logic [24:0] lim_max,
  output logic             line
);
  typedef struct packed {
    logic acc;
    logic line;
  } bafle_lim_t;
  bafle_lim_t st_ff;
  bafle_lim_t nxt_st;
  logic       hit;
  logic       lo_bad;
  logic       hi_bad;

  // Over-limit test on the post-filter value
  assign lo_bad = lim_min[24] && ($signed(smp_val) < $signed(lim_min[23:0]));
  assign hi_bad = lim_max[24] && ($signed(smp_val) > $signed(lim_max[23:0]));
  assign hit = smp_valid && (smp_ch < 6'(bafle_pkg::NCH)) && mask[smp_ch] && (lo_bad || hi_bad);

  // Sticky, or decided per scan
  always_comb
  begin
    nxt_st = st_ff;
    if (latch_en)
    begin
      if (hit)
        nxt_st.line = 1'b1;
    end
    else
    begin
      nxt_st.acc = st_ff.acc | hit;
      if (scan_end)
      begin
        nxt_st.line = st_ff.acc | hit;
        nxt_st.acc = 1'b0;
      end
    end
    if (clr)
      nxt_st = '0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign line = st_ff.line;
endmodule : bafle_limit_line
`default_nettype wire

// ==== hw/bafle_acq.sv ====
// Purpose: Bridge acquisition path, shared FIFO, limit events, clock/sync
// Assumes: Streams come from per-channel filters
// Notes:   Registers over AXI4-Lite; FIFO data read removes the entry
//
// How it works
// - On device-layer entry, acquire the configured number of scans.
// - Enabled channels sampled in parallel, own converter each.
// - Samples calibrated, then stored with a timestamp.
// - Digital inputs sampled while acquiring, at most 1000 per second.
// - Digital samples align to main samples within half the rate ratio.
// - Main data always converted; dropped before FIFO outside device layer.
// - Entries the host reads are removed, never returned.
// - Confidence scan follows main rate up to 500 samples per second.
// - Between 500 and 1000, confidence stays at 500 (here every second tick, half the main rate); stored only when new.
// - At 1000 samples per second, confidence joins every other dataset.
// - Confidence filter: output = 0.01 new + 0.99 previous output.
// - One confidence source list for all channels.
// - Main and confidence data share one FIFO.
// - One sample clock to all converters plus an aligning sync pulse.
// - Eight lines, optional min and max per channel subset.
// - Filtered values compared; over-limit drives line high.
// - Latched lines stay high until reset or next measurement start.
// - Unlatched lines re-evaluated once per scan.
// - Master unit drives sample clock and sync on bus; slaves follow.
// - In device layer each scanlist channel is stored sample-count times.
// - Trigger-initialize clears the FIFO; continuous re-arm does not.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bafle_acq #(
  parameter int DIO_CYC  = bafle_pkg::DIO_CYC,
  parameter int CONF_CYC = bafle_pkg::CONF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        dev_layer,
  input  wire logic        trig_init,
  output logic             acq_done,
  input  wire logic        conv_valid,
  input  wire logic [5:0]  conv_ch,
  input  wire logic [23:0] conv_data,
  input  wire logic        conv_last,
  input  wire logic        conf_valid,
  input  wire logic [5:0]  conf_ch,
  input  wire logic [1:0]  conf_sel,
  input  wire logic [23:0] conf_data,
  output logic             conf_start,
  input  wire logic [15:0] digital_io_lines,
  output logic             adc_sample_clk,
  output logic             adc_sync,
  input  wire logic        sclk_bus_i,
  output logic             sclk_bus_o,
  output logic             sclk_bus_oe_n,
  input  wire logic        sync_bus_i,
  output logic             sync_bus_o,
  output logic             sync_bus_oe_n,
  output logic [7:0]       trig_lines
);
  typedef struct packed {
    logic aw_ok; logic [7:0] awaddr; logic w_ok; logic [31:0] wdata;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata;
    logic [1:0] rresp; logic master; logic latch_en; logic [23:0] scnt;
    logic [23:0] rdiv; logic [47:0] ch_en; logic [3:0] csrc;
    logic [15:0] gain; logic [23:0] offs;
    logic [7:0][47:0] lmask; logic [7:0][24:0] lmin; logic [7:0][24:0] lmax;
    logic [63:0][49:0] fifo; logic [5:0] wp; logic [5:0] rp;
    logic [6:0] cnt; logic ovf;
    logic [23:0] div; logic tick; logic sync; logic [15:0] ts;
    logic [15:0] dio_cnt; logic dio_due; logic [15:0] conf_cnt; logic conf_go;
    logic dev_q; logic acq_on; logic [23:0] done; logic acq_done;
    logic [2:0] clk_s; logic [2:0] syn_s; logic [2:0][15:0] dio_s;
    logic clk_st; logic syn_st; logic [15:0] dio_st;
    logic [191:0][23:0] iir; logic conf_pend; logic [49:0] conf_word;
    logic dio_pend; logic [49:0] dio_word;
  } bafle_state_t;

  bafle_state_t        st_ff;
  bafle_state_t        nxt_st;
  logic signed [39:0]  prod;
  logic [23:0]         cal;
  logic [7:0]          cidx;
  logic signed [24:0]  cdiff;
  logic signed [32:0]  cstep;
  logic [23:0]         cnew;
  logic [7:0]          rlo;
  logic [7:0]          wlo;
  logic                main_wr;
  logic                scan_end;

  // ----------------------------------------------------------------
  // Calibration and confidence filter datapath
  // ----------------------------------------------------------------
  // gain Q1.14, then offset
  assign prod = $signed(conv_data) * $signed({1'b0, st_ff.gain[14:0]});
  assign cal = prod[37:14] + st_ff.offs;
  assign cidx = {conf_ch, conf_sel};
  assign cdiff = $signed({conf_data[23], conf_data}) -
                 $signed({st_ff.iir[cidx][23], st_ff.iir[cidx]});
  assign cstep = cdiff * bafle_pkg::IIR_K;
  assign cnew = st_ff.iir[cidx] + 24'(cstep >>> bafle_pkg::IIR_SH);
  assign main_wr = st_ff.acq_on && conv_valid && (conv_ch < 6'(bafle_pkg::NCH))
                   && st_ff.ch_en[conv_ch];
  assign scan_end = conv_valid && conv_last;
  assign rlo = s_axi_araddr - bafle_pkg::OFS_LIM;
  assign wlo = st_ff.awaddr - bafle_pkg::OFS_LIM;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        pop;
    logic        wr_sync;
    logic        fw;
    logic [49:0] fword;
    pop = 1'b0;
    wr_sync = 1'b0;
    fw = 1'b0;
    fword = '0;
    nxt_st = st_ff;
    // Address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_st.w_ok = 1'b1;
      nxt_st.wdata = s_axi_wdata;
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
    // Write once both halves are in; whole words
    if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid)
    begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = bafle_pkg::RESP_OKAY;
      case (st_ff.awaddr)
        bafle_pkg::OFS_CTRL:
        begin
          nxt_st.master = st_ff.wdata[bafle_pkg::CTRL_MASTER];
          nxt_st.latch_en = st_ff.wdata[bafle_pkg::CTRL_LATCH];
          wr_sync = st_ff.wdata[bafle_pkg::CTRL_SYNC];
        end
        bafle_pkg::OFS_STATUS:
          if (st_ff.wdata[bafle_pkg::ST_OVF])
            nxt_st.ovf = 1'b0;
        bafle_pkg::OFS_SCNT:    nxt_st.scnt = st_ff.wdata[23:0];
        bafle_pkg::OFS_RDIV:    nxt_st.rdiv = st_ff.wdata[23:0];
        bafle_pkg::OFS_CHEN_LO: nxt_st.ch_en[31:0] = st_ff.wdata;
        bafle_pkg::OFS_CHEN_HI: nxt_st.ch_en[47:32] = st_ff.wdata[15:0];
        // one source list for every channel
        bafle_pkg::OFS_CSRC:    nxt_st.csrc = st_ff.wdata[3:0];
        bafle_pkg::OFS_GAIN:    nxt_st.gain = st_ff.wdata[15:0];
        bafle_pkg::OFS_OFFS:    nxt_st.offs = st_ff.wdata[23:0];
        default:
          if (st_ff.awaddr >= bafle_pkg::OFS_LIM && st_ff.awaddr < bafle_pkg::OFS_LIM_END)
          begin
            case (wlo[3:2])
              2'h0: nxt_st.lmask[wlo[6:4]][31:0] = st_ff.wdata;
              2'h1: nxt_st.lmask[wlo[6:4]][47:32] = st_ff.wdata[15:0];
              2'h2: nxt_st.lmin[wlo[6:4]] = {st_ff.wdata[31], st_ff.wdata[23:0]};
              default: nxt_st.lmax[wlo[6:4]] = {st_ff.wdata[31], st_ff.wdata[23:0]};
            endcase
          end
          else
            nxt_st.bresp = bafle_pkg::RESP_SLVERR;
      endcase
    end
    // Register read, answered on the next edge
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = bafle_pkg::RESP_OKAY;
      nxt_st.rdata = '0;
      case (s_axi_araddr)
        bafle_pkg::OFS_CTRL:
          nxt_st.rdata = {29'h0000_0000, 1'b0, st_ff.latch_en, st_ff.master};
        bafle_pkg::OFS_STATUS:
          nxt_st.rdata = {21'h00_0000, st_ff.cnt == 7'h00, st_ff.acq_on, st_ff.ovf,
                          1'b0, st_ff.cnt};
        bafle_pkg::OFS_SCNT:    nxt_st.rdata = {8'h00, st_ff.scnt};
        bafle_pkg::OFS_RDIV:    nxt_st.rdata = {8'h00, st_ff.rdiv};
        bafle_pkg::OFS_CHEN_LO: nxt_st.rdata = st_ff.ch_en[31:0];
        bafle_pkg::OFS_CHEN_HI: nxt_st.rdata = {16'h0000, st_ff.ch_en[47:32]};
        bafle_pkg::OFS_CSRC:    nxt_st.rdata = {28'h000_0000, st_ff.csrc};
        bafle_pkg::OFS_GAIN:    nxt_st.rdata = {16'h0000, st_ff.gain};
        bafle_pkg::OFS_OFFS:    nxt_st.rdata = {8'h00, st_ff.offs};
        bafle_pkg::OFS_FTAG:
          nxt_st.rdata = {st_ff.fifo[st_ff.rp][49:34], 6'h00, st_ff.fifo[st_ff.rp][33:24]};
        bafle_pkg::OFS_FDATA:
          // a data read removes the head entry
          if (st_ff.cnt != 7'h00)
          begin
            pop = 1'b1;
            nxt_st.rdata = {{8{st_ff.fifo[st_ff.rp][23]}}, st_ff.fifo[st_ff.rp][23:0]};
          end
        default:
          if (s_axi_araddr >= bafle_pkg::OFS_LIM && s_axi_araddr < bafle_pkg::OFS_LIM_END)
          begin
            case (rlo[3:2])
              2'h0: nxt_st.rdata = st_ff.lmask[rlo[6:4]][31:0];
              2'h1: nxt_st.rdata = {16'h0000, st_ff.lmask[rlo[6:4]][47:32]};
              2'h2: nxt_st.rdata = {st_ff.lmin[rlo[6:4]][24], 7'h00,
                                    st_ff.lmin[rlo[6:4]][23:0]};
              default: nxt_st.rdata = {st_ff.lmax[rlo[6:4]][24], 7'h00,
                                       st_ff.lmax[rlo[6:4]][23:0]};
            endcase
          end
          else
            nxt_st.rresp = bafle_pkg::RESP_SLVERR;
      endcase
    end
    // Pins: three stages; stages two and three must agree
    nxt_st.clk_s = {st_ff.clk_s[1:0], sclk_bus_i};
    nxt_st.syn_s = {st_ff.syn_s[1:0], sync_bus_i};
    nxt_st.dio_s = {st_ff.dio_s[1:0], digital_io_lines};
    if (st_ff.clk_s[2] == st_ff.clk_s[1])
      nxt_st.clk_st = st_ff.clk_s[1];
    if (st_ff.syn_s[2] == st_ff.syn_s[1])
      nxt_st.syn_st = st_ff.syn_s[1];
    if (st_ff.dio_s[2] == st_ff.dio_s[1])
      nxt_st.dio_st = st_ff.dio_s[1];
    // one sample tick and one sync for all converters
    nxt_st.tick = 1'b0;
    if (st_ff.master)
    begin
      nxt_st.sync = wr_sync;
      if (st_ff.div >= st_ff.rdiv - 24'h00_0001)
      begin
        nxt_st.div = '0;
        nxt_st.tick = 1'b1;
      end
      else
        nxt_st.div = st_ff.div + 24'h00_0001;
    end
    else
    begin
      nxt_st.sync = nxt_st.syn_st && !st_ff.syn_st;
      nxt_st.tick = nxt_st.clk_st && !st_ff.clk_st;
    end
    if (nxt_st.tick)
      nxt_st.ts = st_ff.ts + 16'h0001;
    // Sync realigns divider and timestamp
    if (nxt_st.sync)
    begin
      nxt_st.div = '0;
      nxt_st.ts = '0;
    end
    nxt_st.dev_q = dev_layer;
    nxt_st.acq_done = 1'b0;
    if (dev_layer && !st_ff.dev_q && st_ff.scnt != 24'h00_0000)
    begin
      nxt_st.acq_on = 1'b1;
      nxt_st.done = '0;
    end
    else if (!dev_layer)
      nxt_st.acq_on = 1'b0;
    else if (st_ff.acq_on && scan_end)
    begin
      nxt_st.done = st_ff.done + 24'h00_0001;
      if (st_ff.done + 24'h00_0001 == st_ff.scnt)
      begin
        nxt_st.acq_on = 1'b0;
        nxt_st.acq_done = 1'b1;
      end
    end
    // confidence scan on a tick, at least 2 ms apart
    // at 1 kSa/s that is every other dataset
    nxt_st.conf_go = 1'b0;
    if (st_ff.conf_cnt < 16'(CONF_CYC - 1))
      nxt_st.conf_cnt = st_ff.conf_cnt + 16'h0001;
    else if (st_ff.tick)
    begin
      nxt_st.conf_go = 1'b1;
      nxt_st.conf_cnt = '0;
    end
    // digital sample due at most once per millisecond
    if (st_ff.dio_cnt >= 16'(DIO_CYC - 1))
    begin
      nxt_st.dio_cnt = '0;
      nxt_st.dio_due = 1'b1;
    end
    else
      nxt_st.dio_cnt = st_ff.dio_cnt + 16'h0001;
    // taken on next tick, skew under one sample
    if (st_ff.tick && st_ff.dio_due)
    begin
      nxt_st.dio_due = nxt_st.dio_cnt == 16'h0000;
      if (st_ff.acq_on)
      begin
        nxt_st.dio_pend = 1'b1;
        nxt_st.dio_word = {st_ff.ts, bafle_pkg::KIND_DIO, 8'h00, 8'h00, st_ff.dio_st};
      end
    end
    // one port; main, then confidence, then digital
    if (main_wr)
    begin
      fw = 1'b1;
      fword = {st_ff.ts, bafle_pkg::KIND_MAIN, 2'h0, conv_ch, cal};
    end
    else if (st_ff.conf_pend)
    begin
      fw = 1'b1;
      fword = st_ff.conf_word;
      nxt_st.conf_pend = 1'b0;
    end
    else if (st_ff.dio_pend)
    begin
      fw = 1'b1;
      fword = st_ff.dio_word;
      nxt_st.dio_pend = 1'b0;
    end
    // entry only for a new value
    if (conf_valid && conf_ch < 6'(bafle_pkg::NCH))
    begin
      nxt_st.iir[cidx] = cnew;
      if (st_ff.acq_on && st_ff.ch_en[conf_ch] && st_ff.csrc[conf_sel])
      begin
        nxt_st.conf_pend = 1'b1;
        nxt_st.conf_word = {st_ff.ts, bafle_pkg::KIND_CONF, conf_sel, conf_ch, cnew};
      end
    end
    if (fw && st_ff.cnt[6])
    begin
      fw = 1'b0;
      nxt_st.ovf = 1'b1;
    end
    if (fw)
    begin
      nxt_st.fifo[st_ff.wp] = fword;
      nxt_st.wp = st_ff.wp + 6'h01;
    end
    if (pop)
      nxt_st.rp = st_ff.rp + 6'h01;
    nxt_st.cnt = st_ff.cnt + {6'h00, fw} - {6'h00, pop};
    if (trig_init)
    begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
      nxt_st.cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.scnt <= bafle_pkg::SCNT_RST;
      st_ff.rdiv <= bafle_pkg::RDIV_RST;
      st_ff.gain <= bafle_pkg::GAIN_RST;
      st_ff.csrc <= bafle_pkg::CSRC_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Limit lines
  // ----------------------------------------------------------------
  // trigger-initialize restarts latched lines
  for (genvar g = 0; g < bafle_pkg::NLINE; g++)
  begin : g_line
    bafle_limit_line u_line (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clr       (trig_init),
      .smp_valid (conv_valid),
      .smp_ch    (conv_ch),
      .smp_val   (cal),
      .scan_end  (scan_end),
      .latch_en  (st_ff.latch_en),
      .mask      (st_ff.lmask[g]),
      .lim_min   (st_ff.lmin[g]),
      .lim_max   (st_ff.lmax[g]),
      .line      (trig_lines[g])
    );
  end

  // Outputs
  assign s_axi_awready = !st_ff.aw_ok && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_ok && !st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  // every converter gets the same tick and sync
  assign adc_sample_clk = st_ff.tick;
  assign adc_sync       = st_ff.sync;
  assign sclk_bus_o     = st_ff.tick;
  assign sync_bus_o     = st_ff.sync;
  assign sclk_bus_oe_n  = !st_ff.master;
  assign sync_bus_oe_n  = !st_ff.master;
  assign conf_start     = st_ff.conf_go;
  assign acq_done       = st_ff.acq_done;
endmodule : bafle_acq
`default_nettype wire

// ==== bench/bafle_acq_asserts.sv ====
// Purpose: Port-level checks of the acquisition block
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Bound into every bafle_acq instance below
`timescale 1ns/1ns
`default_nettype none
module bafle_acq_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        dev_layer,
  input wire logic        acq_done,
  input wire logic        conf_start,
  input wire logic        adc_sample_clk,
  input wire logic        adc_sync,
  input wire logic        sclk_bus_o,
  input wire logic        sclk_bus_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answer not yet taken
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_rd_data_stands: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed");
  a_rd_taken_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_done_one_pulse: assert property (acq_done |=> !acq_done)
    else $error("acq done too long");
  a_done_needs_layer: assert property (!dev_layer [*2] |-> !acq_done)
    else $error("acq done outside device layer");
  a_tick_one_pulse: assert property (adc_sample_clk |=> !adc_sample_clk)
    else $error("tick too long");
  a_sync_one_pulse: assert property (adc_sync |=> !adc_sync)
    else $error("sync too long");
  a_bus_clk_mirror: assert property (!sclk_bus_oe_n |-> sclk_bus_o == adc_sample_clk)
    else $error("bus clock differs");
  // Confidence scans far apart
  a_conf_start_gap: assert property (conf_start |=> !conf_start [*8])
    else $error("confidence scans too close");
endmodule : bafle_acq_chk
bind bafle_acq bafle_acq_chk bafle_acq_chk_i (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .dev_layer, .acq_done, .conf_start, .adc_sample_clk, .adc_sync, .sclk_bus_o,
  .sclk_bus_oe_n);
`default_nettype wire

// ==== bench/bafle_conv_src.sv ====
// Purpose: Converter stream model, one scan of channels 0 to 2 per go
// Assumes: Same clock as the block
// Notes:   Idle data is inverted, not the last sample
`timescale 1ns/1ns
`default_nettype none
module bafle_conv_src (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [23:0] seed,
  output logic             conv_valid,
  output logic [5:0]       conv_ch,
  output logic [23:0]      conv_data,
  output logic             conv_last
);
  logic [1:0] pos = 2'h3;
  always @(posedge aclk)
    pos <= go ? 2'h0 : (pos == 2'h3 ? pos : pos + 2'h1);
  assign conv_valid = (pos != 2'h3);
  assign conv_ch    = {4'h0, pos};
  assign conv_data  = conv_valid ? seed + {22'h0, pos} : ~seed;
  assign conv_last  = (pos == 2'h2);
endmodule : bafle_conv_src
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Register, FIFO and clock checks of the acquisition block
// Assumes: 100 ns clock, short DIGITAL_IO_LINES and confidence periods
// Notes:   Confidence input idle; FIFO holds main data
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic aclk = 0, aresetn = 0, go = 0, dev_layer = 0, trig_init = 0, sclk_bus_i = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, conf_valid = 0, sync_bus_i = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, acq_done, conf_start, adc_sample_clk;
  logic adc_sync, sclk_bus_o, sclk_bus_oe_n, sync_bus_o, sync_bus_oe_n, conv_valid, conv_last;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, trig_lines;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, conf_sel = 0, r;
  logic [5:0] conf_ch = 0, conv_ch;
  logic [23:0] conf_data = 0, conv_data, seed = 0;
  logic [15:0] digital_io_lines = 16'h5a5a;
  int mismatches = 0, tests_run = 0, ticks = 0, n;
  bafle_acq #(.DIO_CYC(20), .CONF_CYC(40)) bafle_acq_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dev_layer, .trig_init, .acq_done,
    .conv_valid, .conv_ch, .conv_data, .conv_last, .conf_valid, .conf_ch, .conf_sel, .conf_data,
    .conf_start, .digital_io_lines, .adc_sample_clk, .adc_sync, .sclk_bus_i, .sclk_bus_o,
    .sclk_bus_oe_n, .sync_bus_i, .sync_bus_o, .sync_bus_oe_n, .trig_lines);
  bafle_conv_src bafle_conv_src_i (.aclk, .go, .seed, .conv_valid, .conv_ch, .conv_data, .conv_last);
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) ticks <= ticks + adc_sample_clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++)
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    if (n == 50) chk("write wait", 0, 1);
    if (n == 50) tally_and_finish();
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++)
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
    if (n == 50) chk("read wait", 0, 1);
    if (n == 50) tally_and_finish();
    chk(what, exp, d);
  endtask : rd
  task automatic scan(input logic [23:0] s);
    @(posedge aclk);
    {go, seed} <= {1'b1, s};
    @(posedge aclk);
    go <= 0;
    repeat (5) @(posedge aclk);
  endtask : scan
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd("sample count", bafle_pkg::OFS_SCNT, 32'h0000_0001);
    rd("gain", bafle_pkg::OFS_GAIN, 32'h0000_4000);
    rd("conf sources", bafle_pkg::OFS_CSRC, 32'h0000_0001);
    rd("unmapped", 8'hfc, 32'h0000_0000);
    chk("unmapped resp", {30'h0, bafle_pkg::RESP_SLVERR}, {30'h0, r});
    $display("test registers done");
    wr(bafle_pkg::OFS_CHEN_LO, 32'h0000_0003);
    wr(bafle_pkg::OFS_SCNT, 32'h0000_0002);
    wr(bafle_pkg::OFS_OFFS, 32'h0000_0010);
    repeat (3)
    begin
      sclk_bus_i <= 1;
      repeat (8) @(posedge aclk);
      sclk_bus_i <= 0;
      repeat (8) @(posedge aclk);
    end
    chk("slave ticks", 3, ticks);
    scan(24'h00_0100);
    rd("idle fifo", bafle_pkg::OFS_STATUS, 32'h0000_0400);
    trig_init <= 1;
    dev_layer <= 1;
    @(posedge aclk);
    trig_init <= 0;
    scan(24'h00_0200);
    scan(24'h00_0300);
    scan(24'h00_0400);
    rd("stored count", bafle_pkg::OFS_STATUS, 32'h0000_0004);
    dev_layer <= 0;
    for (int i = 0; i < 4; i++)
      rd("fifo data", bafle_pkg::OFS_FDATA, 32'h0000_0210 + 32'(i / 2 * 256 + i % 2));
    rd("drained", bafle_pkg::OFS_FDATA, 32'h0000_0000);
    $display("test fifo done");
    wr(bafle_pkg::OFS_LIM, 32'h0000_0001);
    wr(bafle_pkg::OFS_LIM + 8'h0c, 32'h8000_0100);
    scan(24'h00_0200);
    chk("limit line", 1, {31'h0, trig_lines[0]});
    wr(bafle_pkg::OFS_RDIV, 32'h0000_0008);
    wr(bafle_pkg::OFS_CTRL, 32'h0000_0005);
    repeat (100) @(posedge aclk);
    chk("master drive", 0, {31'h0, sclk_bus_oe_n});
    $display("test master done");
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
